/* common/smbus_pkg.sv */
package smbus_pkg;
    // Device addressing
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2e;
    localparam logic [6:0] DEV_ADDR_ALT0    = 7'h2c;
    localparam logic [6:0] DEV_ADDR_ALT1    = 7'h2d;
    localparam logic [6:0] ALERT_RESP_ADDR  = 7'h0c;
    localparam logic [1:0] STRAP_SETTLE     = 2'h3;
    localparam logic [3:0] BYTE_BITS        = 4'h8;
    // Device register
    localparam logic [7:0] FIRST_CFG_OFS    = 8'h40;
    localparam logic [7:0] FIRST_CFG_RST    = 8'h00;
    localparam int         TIMEOUT_DIS_BIT  = 6;
    // Timing
    localparam int CLK_HZ      = 25_000_000;
    localparam int TIMEOUT_MS  = 35;
    localparam int TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int SCL_QTR_CYC = 2;
    // Controller registers
    localparam logic [7:0] CMD_OFS      = 8'h00;
    localparam logic [7:0] STAT_OFS     = 8'h04;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
    localparam logic [7:0] IRQ_CLR_OFS  = 8'h0c;
    localparam logic [7:0] IRQ_EN_OFS   = 8'h10;
    localparam int IRQ_DONE  = 0;
    localparam int IRQ_NACK  = 1;
    localparam int IRQ_ALERT = 2;
    // Controller byte items
    localparam logic [1:0] K_WR   = 2'h0;
    localparam logic [1:0] K_RD   = 2'h1;
    localparam logic [1:0] K_RS   = 2'h2;
    localparam logic [1:0] K_STOP = 2'h3;

    typedef enum logic [2:0] {
        OP_NONE, OP_SEND, OP_WRITE, OP_RECV, OP_ARA, OP_SEND_RECV
    } host_op_e;

    typedef enum logic [3:0] {
        DS_IDLE     = 4'h0,
        DS_ADDR     = 4'h1,
        DS_ADDR_ACK = 4'h3,
        DS_CMD      = 4'h2,
        DS_CMD_ACK  = 4'h6,
        DS_DATA     = 4'h7,
        DS_DATA_ACK = 4'h5,
        DS_READ     = 4'h4,
        DS_READ_ACK = 4'hc,
        DS_IGNORE   = 4'hd
    } dev_state_e;

    typedef enum logic [2:0] {
        HS_IDLE   = 3'h0,
        HS_START  = 3'h1,
        HS_BITS   = 3'h3,
        HS_STOP   = 3'h2,
        HS_RSTART = 3'h6
    } host_state_e;
endpackage

/* common/smbus_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface smbus_if;
    // Open-drain pulls: high enable pulls the wire low
    logic      host_scl_oe;
    logic      host_sda_oe;
    logic      dev_sda_oe;
    logic      dev_alert_oe;
    wire logic scl;
    wire logic sda;
    wire logic alert_n;

    assign scl     = ~host_scl_oe;
    assign sda     = ~(host_sda_oe | dev_sda_oe);
    assign alert_n = ~dev_alert_oe;

    modport device (input scl, input sda,
                    output dev_sda_oe, output dev_alert_oe);
    modport host (input scl, input sda, input alert_n,
                  output host_scl_oe, output host_sda_oe);
endinterface
`default_nettype wire

/* core/smbus_dev.sv */
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Send byte: address write, command, stop
// - Send byte command loads register pointer
// - Repeated start after command allows read
// - Write byte: address, command, data, all acked
// - Receive byte: address read, data, master nacks
// - Receive byte returns register at pointer
// - Acknowledge only own address, and alert response address while alerting
// - Answer alert response address with own address
// - Alert response address never assigned to device
// - Lose alert arbitration to lower address
// - Alert released only when cause gone
// - Alert usable as shared wired interrupt
// - Release bus after 35 ms idle
// - Config bit 6 disables timeout, default enabled
// - Default address 0101110 unless strap selects
// - Strap sampled once at powerup, then fixed
// - First write byte is pointer, second data
module smbus_dev #(
    parameter int TIMEOUT_CYCLES = smbus_pkg::TIMEOUT_CYC
) (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    // Serial bus
    smbus_if.device         bus,
    // Straps and alert source
    input  wire logic       address_select_strap,
    input  wire logic       address_pin_strap,
    input  wire logic       alert_cause,
    // Register file port
    output logic [7:0]      reg_ptr,
    output logic [7:0]      reg_wdata,
    output logic            reg_we,
    input  wire logic [7:0] reg_rdata,
    // Status
    output logic            bus_timeout_disable,
    output logic            alert_irq
);
    import smbus_pkg::*;

    localparam int TW = $clog2(TIMEOUT_CYCLES + 1);

    typedef struct packed {
        logic [2:0]  scl_s;
        logic [2:0]  sda_s;
        logic [1:0]  strap_a;
        logic [1:0]  strap_b;
        logic [1:0]  strap_cnt;
        logic [6:0]  own_addr;
        dev_state_e  st;
        logic [3:0]  cnt;
        logic [7:0]  sh;
        logic [7:0]  tx;
        logic        rw;
        logic        ara;
        logic        sda_oe;
        logic [7:0]  ptr;
        logic [7:0]  cfg;
        logic [7:0]  wdata;
        logic        we;
        logic        alert;
        logic [TW-1:0] tmo;
    } dev_s;

    dev_s s_r;
    dev_s s_nxt;

    logic scl;
    logic scl_p;
    logic sda;
    logic sda_p;
    logic rise;
    logic fall;
    logic start_c;
    logic stop_c;
    logic timeout;
    logic [7:0] rd_byte;

    // Stage 0 of each synchroniser feeds stage 1 only
    assign scl     = s_r.scl_s[1];
    assign scl_p   = s_r.scl_s[2];
    assign sda     = s_r.sda_s[1];
    assign sda_p   = s_r.sda_s[2];
    assign rise    = scl & ~scl_p;
    assign fall    = ~scl & scl_p;
    assign start_c = scl & scl_p & sda_p & ~sda;
    assign stop_c  = scl & scl_p & ~sda_p & sda;
    assign timeout = ~s_r.cfg[TIMEOUT_DIS_BIT] &
                     (s_r.tmo == TW'(TIMEOUT_CYCLES));
    // Config register is local; every other register is outside
    assign rd_byte = s_r.ara ? {s_r.own_addr, 1'b0} :
                     (s_r.ptr == FIRST_CFG_OFS) ? s_r.cfg :
                     reg_rdata;

    always_comb begin
        logic ara_done;
        ara_done = 1'b0;
        s_nxt = s_r;
        s_nxt.we = 1'b0;
        s_nxt.scl_s = {s_r.scl_s[1:0], bus.scl};
        s_nxt.sda_s = {s_r.sda_s[1:0], bus.sda};
        s_nxt.strap_a = {address_select_strap, address_pin_strap};
        s_nxt.strap_b = s_r.strap_a;
        // Address follows the strap only until it settles
        if (s_r.strap_cnt != STRAP_SETTLE) begin
            s_nxt.strap_cnt = s_r.strap_cnt + 2'h1;
            s_nxt.own_addr = s_r.strap_b[1] ? DEV_ADDR_DEFAULT :
                             s_r.strap_b[0] ? DEV_ADDR_ALT1 :
                             DEV_ADDR_ALT0;
        end
        // Idle timer restarts on any line change
        if (s_r.st == DS_IDLE || scl != scl_p || sda != sda_p) begin
            s_nxt.tmo = '0;
        end else if (s_r.tmo != TW'(TIMEOUT_CYCLES)) begin
            s_nxt.tmo = s_r.tmo + TW'(1);
        end

        if (start_c) begin
            s_nxt.st = DS_ADDR;
            s_nxt.cnt = '0;
            s_nxt.sda_oe = 1'b0;
            s_nxt.ara = 1'b0;
        end else if (stop_c) begin
            s_nxt.st = DS_IDLE;
            s_nxt.sda_oe = 1'b0;
        end else if (timeout) begin
            s_nxt.st = DS_IDLE;
            s_nxt.sda_oe = 1'b0;
        end else begin
            case (s_r.st)
                DS_ADDR, DS_CMD, DS_DATA: begin
                    if (rise) begin
                        s_nxt.sh = {s_r.sh[6:0], sda};
                        s_nxt.cnt = s_r.cnt + 4'h1;
                    end else if (fall && s_r.cnt == BYTE_BITS) begin
                        s_nxt.cnt = '0;
                        s_nxt.sda_oe = 1'b1;
                        if (s_r.st == DS_ADDR) begin
                            s_nxt.rw = s_r.sh[0];
                            s_nxt.ara = (s_r.sh[7:1] == ALERT_RESP_ADDR)
                                        & s_r.sh[0] & s_r.alert;
                            if (s_r.sh[7:1] == s_r.own_addr || s_nxt.ara) begin
                                s_nxt.st = DS_ADDR_ACK;
                            end else begin
                                s_nxt.st = DS_IGNORE;
                                s_nxt.sda_oe = 1'b0;
                            end
                        end else if (s_r.st == DS_CMD) begin
                            s_nxt.ptr = s_r.sh;
                            s_nxt.st = DS_CMD_ACK;
                        end else begin
                            s_nxt.wdata = s_r.sh;
                            s_nxt.we = 1'b1;
                            if (s_r.ptr == FIRST_CFG_OFS) begin
                                s_nxt.cfg = s_r.sh;
                            end
                            s_nxt.st = DS_DATA_ACK;
                        end
                    end
                end
                DS_ADDR_ACK: begin
                    if (fall) begin
                        if (s_r.rw) begin
                            s_nxt.tx = rd_byte;
                            s_nxt.sda_oe = ~rd_byte[7];
                            s_nxt.st = DS_READ;
                        end else begin
                            s_nxt.sda_oe = 1'b0;
                            s_nxt.st = DS_CMD;
                        end
                    end
                end
                DS_CMD_ACK: begin
                    if (fall) begin
                        s_nxt.sda_oe = 1'b0;
                        s_nxt.st = DS_DATA;
                    end
                end
                DS_DATA_ACK: begin
                    // Only two bytes per write; later bytes are not acked
                    if (fall) begin
                        s_nxt.sda_oe = 1'b0;
                        s_nxt.st = DS_IGNORE;
                    end
                end
                DS_READ: begin
                    if (rise) begin
                        if (!s_r.sda_oe && !sda) begin
                            s_nxt.st = DS_IGNORE;
                        end else begin
                            s_nxt.cnt = s_r.cnt + 4'h1;
                        end
                    end else if (fall) begin
                        if (s_r.cnt == BYTE_BITS) begin
                            s_nxt.sda_oe = 1'b0;
                            s_nxt.st = DS_READ_ACK;
                            ara_done = s_r.ara;
                        end else begin
                            s_nxt.tx = {s_r.tx[6:0], 1'b0};
                            s_nxt.sda_oe = ~s_r.tx[6];
                        end
                    end
                end
                DS_READ_ACK: begin
                    // Single-byte reads: rest of the frame is ignored
                    if (rise) begin
                        s_nxt.st = DS_IGNORE;
                    end
                end
                DS_IDLE, DS_IGNORE: begin
                    s_nxt.sda_oe = 1'b0;
                end
                default: begin
                    s_nxt.st = DS_IDLE;
                    s_nxt.sda_oe = 1'b0;
                end
            endcase
        end
        // A live cause keeps the alert even as it is answered
        s_nxt.alert = alert_cause | (s_r.alert & ~ara_done);
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            s_r <= '0;
            s_r.scl_s <= 3'h7;
            s_r.sda_s <= 3'h7;
            s_r.own_addr <= DEV_ADDR_DEFAULT;
            s_r.cfg <= FIRST_CFG_RST;
            s_r.st <= DS_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign bus.dev_sda_oe    = s_r.sda_oe;
    assign bus.dev_alert_oe  = s_r.alert;
    assign reg_ptr           = s_r.ptr;
    assign reg_wdata         = s_r.wdata;
    assign reg_we            = s_r.we;
    assign bus_timeout_disable = s_r.cfg[TIMEOUT_DIS_BIT];
    assign alert_irq         = s_r.alert;
endmodule // smbus_dev
`default_nettype wire

/* core/smbus_host.sv */
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module smbus_host #(
    parameter int QTR_CYCLES = smbus_pkg::SCL_QTR_CYC
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Interrupt
    output logic             irq,
    // Serial bus
    smbus_if.host            bus
);
    import smbus_pkg::*;

    localparam int QW = $clog2(QTR_CYCLES + 1);

    typedef struct packed {
        logic [1:0]    sda_s;
        logic [1:0]    alert_s;
        logic [QW-1:0] div;
        host_state_e   st;
        logic [1:0]    ph;
        logic [3:0]    bitn;
        logic [2:0]    idx;
        host_op_e      op;
        logic [6:0]    addr;
        logic [7:0]    cmd;
        logic [7:0]    data;
        logic [8:0]    tx;
        logic          rd;
        logic [7:0]    rx;
        logic          scl_oe;
        logic          sda_oe;
        logic          nack;
        logic          busy;
        logic [2:0]    irq_st;
        logic [2:0]    irq_en;
        logic          wr_pend;
        logic [7:0]    wa;
        logic [31:0]   rdata;
    } host_s;

    host_s s_r;
    host_s s_nxt;
    logic  tick;
    logic  [9:0] item;

    // Byte plan of each operation: kind and byte at each index
    function automatic logic [9:0] item_at(host_op_e op, logic [2:0] i,
                                           logic [6:0] a, logic [7:0] c,
                                           logic [7:0] d);
        logic [9:0] r;
        logic       rdop;
        r = {K_STOP, 8'h00};
        rdop = (op == OP_RECV) || (op == OP_ARA);
        case (i)
            3'h0: r = {K_WR, (op == OP_ARA) ? ALERT_RESP_ADDR : a, rdop};
            3'h1: r = rdop ? {K_RD, 8'hff} : {K_WR, c};
            3'h2: begin
                if (op == OP_WRITE) begin
                    r = {K_WR, d};
                end else if (op == OP_SEND_RECV) begin
                    r = {K_RS, 8'h00};
                end
            end
            3'h3: if (op == OP_SEND_RECV) r = {K_WR, a, 1'b1};
            3'h4: if (op == OP_SEND_RECV) r = {K_RD, 8'hff};
            default: r = {K_STOP, 8'h00};
        endcase
        return r;
    endfunction

    assign tick = (s_r.div == QW'(QTR_CYCLES - 1));
    assign item = item_at(s_r.op, s_r.idx, s_r.addr, s_r.cmd, s_r.data);

    always_comb begin
        logic       go_next;
        logic [2:0] ev;
        logic [2:0] clr;
        go_next = 1'b0;
        ev = '0;
        clr = '0;
        s_nxt = s_r;
        s_nxt.sda_s = {s_r.sda_s[0], bus.sda};
        s_nxt.alert_s = {s_r.alert_s[0], bus.alert_n};
        s_nxt.div = tick ? '0 : s_r.div + QW'(1);
        ev[IRQ_ALERT] = ~s_r.alert_s[1];
        if (tick && s_r.st != HS_IDLE) begin
            s_nxt.ph = s_r.ph + 2'h1;
            case (s_r.st)
                HS_START: begin
                    if (s_r.ph == 2'h0) s_nxt.sda_oe = 1'b1;
                    if (s_r.ph == 2'h3) begin
                        s_nxt.scl_oe = 1'b1;
                        go_next = 1'b1;
                    end
                end
                HS_BITS: begin
                    case (s_r.ph)
                        2'h0: s_nxt.sda_oe = ~s_r.tx[8];
                        2'h1: s_nxt.scl_oe = 1'b0;
                        2'h2: begin
                            if (s_r.bitn != BYTE_BITS) begin
                                if (s_r.rd) s_nxt.rx = {s_r.rx[6:0], s_r.sda_s[1]};
                            end else if (!s_r.rd && s_r.sda_s[1]) begin
                                s_nxt.nack = 1'b1;
                            end
                        end
                        default: begin
                            s_nxt.scl_oe = 1'b1;
                            s_nxt.tx = {s_r.tx[7:0], 1'b1};
                            s_nxt.bitn = s_r.bitn + 4'h1;
                            if (s_r.bitn == BYTE_BITS) begin
                                s_nxt.bitn = '0;
                                if (s_r.nack) s_nxt.st = HS_STOP;
                                else go_next = 1'b1;
                            end
                        end
                    endcase
                end
                HS_RSTART: begin
                    case (s_r.ph)
                        2'h0: s_nxt.sda_oe = 1'b0;
                        2'h1: s_nxt.scl_oe = 1'b0;
                        2'h2: s_nxt.sda_oe = 1'b1;
                        default: begin
                            s_nxt.scl_oe = 1'b1;
                            go_next = 1'b1;
                        end
                    endcase
                end
                HS_STOP: begin
                    case (s_r.ph)
                        2'h0: s_nxt.sda_oe = 1'b1;
                        2'h1: s_nxt.scl_oe = 1'b0;
                        2'h2: s_nxt.sda_oe = 1'b0;
                        default: begin
                            s_nxt.st = HS_IDLE;
                            s_nxt.busy = 1'b0;
                            ev[IRQ_DONE] = 1'b1;
                            ev[IRQ_NACK] = s_r.nack;
                        end
                    endcase
                end
                default: s_nxt.st = HS_IDLE;
            endcase
        end
        if (go_next) begin
            s_nxt.idx = s_r.idx + 3'h1;
            s_nxt.tx = {item[7:0], 1'b1};
            s_nxt.rd = (item[9:8] == K_RD);
            case (item[9:8])
                K_WR, K_RD: s_nxt.st = HS_BITS;
                K_RS: s_nxt.st = HS_RSTART;
                default: s_nxt.st = HS_STOP;
            endcase
        end
        // Write data phase; a command while busy is dropped
        if (s_r.wr_pend) begin
            case (s_r.wa)
                CMD_OFS: begin
                    if (!s_r.busy && hwdata[2:0] != 3'h0 && hwdata[2:0] < 3'h6) begin
                        s_nxt.op = host_op_e'(hwdata[2:0]);
                        s_nxt.addr = hwdata[14:8];
                        s_nxt.cmd = hwdata[23:16];
                        s_nxt.data = hwdata[31:24];
                        s_nxt.st = HS_START;
                        s_nxt.ph = '0;
                        s_nxt.div = '0;
                        s_nxt.idx = '0;
                        s_nxt.nack = 1'b0;
                        s_nxt.rx = '0;
                        s_nxt.busy = 1'b1;
                    end
                end
                IRQ_CLR_OFS: clr = hwdata[2:0];
                IRQ_EN_OFS: s_nxt.irq_en = hwdata[2:0];
                default: ;
            endcase
        end
        s_nxt.wr_pend = 1'b0;
        if (hsel && hready && htrans[1]) begin
            if (hwrite) begin
                s_nxt.wr_pend = 1'b1;
                s_nxt.wa = haddr[7:0];
            end else begin
                case (haddr[7:0])
                    CMD_OFS: s_nxt.rdata = {s_r.data, s_r.cmd, 1'b0, s_r.addr,
                                            5'h00, s_r.op};
                    STAT_OFS: s_nxt.rdata = {16'h0000, s_r.rx, 5'h00,
                                             ~s_r.alert_s[1], s_r.nack, s_r.busy};
                    IRQ_STAT_OFS: s_nxt.rdata = {29'h0, s_r.irq_st};
                    IRQ_EN_OFS: s_nxt.rdata = {29'h0, s_r.irq_en};
                    default: s_nxt.rdata = 32'h0000_0000;
                endcase
            end
        end
        // A new event wins over a clear in the same cycle
        s_nxt.irq_st = (s_r.irq_st & ~clr) | ev;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            s_r <= '0;
            s_r.sda_s <= 2'h3;
            s_r.alert_s <= 2'h3;
            s_r.st <= HS_IDLE;
            s_r.op <= OP_NONE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign bus.host_scl_oe = s_r.scl_oe;
    assign bus.host_sda_oe = s_r.sda_oe;
    assign hrdata    = s_r.rdata;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign irq       = |(s_r.irq_st & s_r.irq_en);
endmodule // smbus_host
`default_nettype wire

/* tb/smbus_slave_alert_timeout_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module smbus_slave_alert_timeout_chk #(
    parameter int TIMEOUT_CYCLES = 200
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Wire pulls and levels
    input wire logic host_scl_oe,
    input wire logic host_sda_oe,
    input wire logic dev_sda_oe,
    input wire logic dev_alert_oe,
    input wire logic scl,
    input wire logic sda,
    input wire logic alert_n,
    // Alert source
    input wire logic alert_cause
);
    logic [19:0] quiet_r;
    always_ff @(posedge ref_clk) begin
        if (!rst_b || $changed(scl) || $changed(sda)) quiet_r <= 20'h0;
        else quiet_r <= quiet_r + 20'h1;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    sequence s_start; scl && $fell(sda); endsequence
    sequence s_stop; scl && $rose(sda); endsequence
    chk_dev_edge_low: assert property ($changed(dev_sda_oe) |-> !scl)
        else $error("device data moved while clock high");
    chk_dev_bit_hold: assert property ($rose(scl) |=> $stable(dev_sda_oe)[*3])
        else $error("device bit not held over clock high");
    chk_start_by_host: assert property (s_start |-> host_sda_oe)
        else $error("start not made by host");
    chk_stop_not_dev: assert property (s_stop |-> !dev_sda_oe)
        else $error("device pull during stop");
    chk_idle_after_stop: assert property (s_stop |=> (!dev_sda_oe)[*8])
        else $error("device pulls data after stop");
    chk_timeout_free: assert property (quiet_r >= TIMEOUT_CYCLES + 8 |-> !dev_sda_oe)
        else $error("data held past timeout");
    chk_alert_raise: assert property ($rose(alert_cause) |-> ##[1:3] !alert_n)
        else $error("alert not raised");
    chk_alert_release: assert property ($rose(alert_n) |-> !$past(alert_cause))
        else $error("alert released with cause present");
endmodule // smbus_slave_alert_timeout_chk
`default_nettype wire

/* tb/test_smbus_slave_alert_timeout.sv */
`timescale 1ns/10ps
`default_nettype none
module test_smbus_slave_alert_timeout;
    import smbus_pkg::*;
    localparam int TO = 200;
    logic ref_clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q, st;
    logic hreadyout, hresp, irq, cfg_dis, alert_irq, reg_we, alert_cause = 1'b0;
    logic [7:0] reg_ptr, reg_wdata;
    int failures = 0, n_checks = 0;
    smbus_if i_smbus_if ();
    smbus_if i_smbus_if_b ();
    smbus_dev #(.TIMEOUT_CYCLES(TO)) i_smbus_dev (.ref_clk(ref_clk),
        .rst_b(rst_b), .bus(i_smbus_if.device), .address_select_strap(1'b1),
        .address_pin_strap(1'b0), .alert_cause(alert_cause), .reg_ptr(reg_ptr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_rdata(~reg_ptr),
        .bus_timeout_disable(cfg_dis), .alert_irq(alert_irq));
    smbus_dev #(.TIMEOUT_CYCLES(TO)) i_smbus_dev_b (.ref_clk(ref_clk),
        .rst_b(rst_b), .bus(i_smbus_if_b.device), .address_select_strap(1'b0),
        .address_pin_strap(1'b1), .alert_cause(alert_cause), .reg_ptr(),
        .reg_wdata(), .reg_we(), .reg_rdata(reg_ptr),
        .bus_timeout_disable(), .alert_irq());
    smbus_host i_smbus_host (.ref_clk(ref_clk), .rst_b(rst_b), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .bus(i_smbus_if.host));
    smbus_slave_alert_timeout_chk #(.TIMEOUT_CYCLES(TO)) i_chk (
        .ref_clk(ref_clk), .rst_b(rst_b), .scl(i_smbus_if.scl),
        .host_scl_oe(i_smbus_if.host_scl_oe), .sda(i_smbus_if.sda),
        .host_sda_oe(i_smbus_if.host_sda_oe), .alert_n(i_smbus_if.alert_n),
        .dev_sda_oe(i_smbus_if.dev_sda_oe), .alert_cause(alert_cause),
        .dev_alert_oe(i_smbus_if.dev_alert_oe));
    always #20 ref_clk = ~ref_clk;
    task automatic close_out;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0; hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic run(input logic [2:0] op, input logic [6:0] ad,
                       input logic [7:0] c, input logic [7:0] dt);
        bus(1'b1, CMD_OFS, {dt, c, 1'b0, ad, 5'h0, op}, st);
        do bus(1'b0, STAT_OFS, 32'h0, st); while (st[0] !== 1'b0);
    endtask
    task automatic t_write;
        run(OP_WRITE, DEV_ADDR_DEFAULT, 8'h12, 8'ha5);
        cmp({st[1], reg_ptr, reg_wdata}, {1'b0, 8'h12, 8'ha5});
        run(OP_WRITE, DEV_ADDR_DEFAULT, FIRST_CFG_OFS, 8'h40);
        cmp(cfg_dis, 1'b1);
        run(OP_SEND_RECV, DEV_ADDR_DEFAULT, FIRST_CFG_OFS, 8'h0);
        cmp(st[15:8], 8'h40);
        run(OP_WRITE, DEV_ADDR_DEFAULT, FIRST_CFG_OFS, 8'h0);
        cmp(cfg_dis, 1'b0);
    endtask
    task automatic t_send_recv;
        run(OP_SEND, DEV_ADDR_DEFAULT, 8'h33, 8'h0);
        cmp({st[1], reg_ptr}, {1'b0, 8'h33});
        repeat (2) begin
            run(OP_RECV, DEV_ADDR_DEFAULT, 8'h0, 8'h0);
            cmp({st[1], st[15:8]}, {1'b0, 8'hcc});
        end
        run(OP_SEND, DEV_ADDR_ALT1, 8'h55, 8'h0);
        cmp({st[1], reg_ptr}, {1'b1, 8'h33});
    endtask
    task automatic t_alert;
        bus(1'b1, IRQ_EN_OFS, 32'h4, q);
        alert_cause <= 1'b1;
        repeat (6) @(posedge ref_clk);
        cmp({i_smbus_if.alert_n, irq, alert_irq}, 3'b011);
        bus(1'b1, IRQ_EN_OFS, 32'h0, q);
        @(posedge ref_clk);
        cmp(irq, 1'b0);
        run(OP_ARA, ALERT_RESP_ADDR, 8'h0, 8'h0);
        cmp(st[15:8], {DEV_ADDR_DEFAULT, 1'b0});
        alert_cause <= 1'b0;
        repeat (4) @(posedge ref_clk);
        cmp(i_smbus_if.alert_n, 1'b0);
        run(OP_ARA, ALERT_RESP_ADDR, 8'h0, 8'h0);
        repeat (4) @(posedge ref_clk);
        cmp(i_smbus_if.alert_n, 1'b1);
        bus(1'b1, IRQ_CLR_OFS, 32'h7, q);
        bus(1'b0, IRQ_STAT_OFS, 32'h0, q);
        cmp(q[2:0], 3'h0);
    endtask
    task automatic bang(input logic [7:0] b);
        i_smbus_if_b.host_sda_oe <= 1'b1;
        repeat (4) @(posedge ref_clk);
        for (int i = 7; i >= 0; i--) begin
            i_smbus_if_b.host_scl_oe <= 1'b1;
            repeat (4) @(posedge ref_clk);
            i_smbus_if_b.host_sda_oe <= ~b[i];
            repeat (4) @(posedge ref_clk);
            i_smbus_if_b.host_scl_oe <= 1'b0;
            repeat (4) @(posedge ref_clk);
        end
        i_smbus_if_b.host_scl_oe <= 1'b1;
        i_smbus_if_b.host_sda_oe <= 1'b0;
        repeat (6) @(posedge ref_clk);
    endtask
    // Second bus by hand: stall, then lose arbitration
    task automatic t_timeout;
        bang({DEV_ADDR_ALT1, 1'b0});
        cmp(i_smbus_if_b.dev_sda_oe, 1'b1);
        repeat (TO + 20) @(posedge ref_clk);
        cmp(i_smbus_if_b.dev_sda_oe, 1'b0);
        i_smbus_if_b.host_scl_oe <= 1'b0;
        repeat (4) @(posedge ref_clk);
        bang({ALERT_RESP_ADDR, 1'b1});
        cmp(i_smbus_if_b.dev_sda_oe, 1'b1);
        for (int i = 0; i < 3; i++) begin
            i_smbus_if_b.host_scl_oe <= 1'b0;
            repeat (4) @(posedge ref_clk);
            i_smbus_if_b.host_scl_oe <= 1'b1;
            i_smbus_if_b.host_sda_oe <= (i == 1);
            repeat (8) @(posedge ref_clk);
        end
        cmp(i_smbus_if_b.dev_sda_oe, 1'b0);
    endtask
    initial begin
        i_smbus_if_b.host_scl_oe = 1'b0;
        i_smbus_if_b.host_sda_oe = 1'b0;
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (10) @(posedge ref_clk);
        cmp(cfg_dis, 1'b0);
        bus(1'b0, 8'h20, 32'h0, q);
        cmp(q, 32'h0);
        t_write();
        t_send_recv();
        t_alert();
        t_timeout();
        close_out();
    end
    initial begin
        repeat (60000) @(posedge ref_clk);
        failures++;
        close_out();
    end
endmodule // test_smbus_slave_alert_timeout
`default_nettype wire
